// ===== src/mcs_pkg.sv
// constants and types for the monitor control and status registers
// ==========================================================================
// Behaviour
// - control_three bit 0 enables hfreq_in and hfreq_out port pins.
// - control_three bit 1 is the upper horizontal dummy frequency select bit.
// - control_three bit 2 sets hfreq_out polarity, 1 inverts.
// - control_three bit 3 halves hfreq_out frequency when set.
// - control_three bit 4 selects external data RAM bank; bits 5-7 unused.
// - port1_alt_enable bit n routes static PWM DAC n to port 1 pin n.
// - port2_alt_enable bits 0-2 route DAC 8-10, bit 3 the clamp pulse.
// - port2_alt_enable bits 4-7 turn port 2 pins 4-7 into converter inputs.
// - port3_alt_enable bits 3 and 4 route horizontal and vertical sync out.
// - 12-bit horizontal count readable as low byte and high byte bits 0-3.
// - hcount_high bit 6 shows horizontal sync missing.
// - hcount_high bit 7 shows horizontal sync polarity, 1 is negative.
// - 12-bit vertical count readable as low byte and high byte bits 0-3.
// - vcount_high bit 6 shows vertical sync missing.
// - vcount_high bit 7 shows vertical sync polarity, 1 is negative.
// - irq_pending holds six sticky source flags at fixed bit positions.
// - bit 4 sets per vsync pulse or once when vsync goes missing.
// - irq_enable bit n enables pending source n.
// - writing 1 to an irq_ack bit clears that pending flag.
// - 13-bit parabola period, read/write over low and high registers.
package mcs_pkg;

  // ========================================================================
  // register offsets
  localparam logic [7:0] OFS_PORT1_ALT     = 8'h82;
  localparam logic [7:0] OFS_PORT2_ALT     = 8'h83;
  localparam logic [7:0] OFS_PORT3_ALT     = 8'h84;
  localparam logic [7:0] OFS_PARA_LOW      = 8'h85;
  localparam logic [7:0] OFS_PARA_HIGH     = 8'h86;
  localparam logic [7:0] OFS_HCOUNT_LOW    = 8'h87;
  localparam logic [7:0] OFS_HCOUNT_HIGH   = 8'h88;
  localparam logic [7:0] OFS_VCOUNT_LOW    = 8'h89;
  localparam logic [7:0] OFS_VCOUNT_HIGH   = 8'h8a;
  localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h8f;
  localparam logic [7:0] OFS_IRQ_PENDING   = 8'h90;
  localparam logic [7:0] OFS_IRQ_ACK       = 8'h91;
  localparam logic [7:0] OFS_CONTROL_THREE = 8'ha0;

  // ========================================================================
  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [4:0]  RST_PARA_HIGH = 5'h00;
  localparam logic [5:0]  RST_IRQ  = 6'h00;

  // ========================================================================
  // field positions
  localparam int C3_HF_EN = 0;
  localparam int C3_HDUM  = 1;
  localparam int C3_POL   = 2;
  localparam int C3_HALF  = 3;
  localparam int C3_BANK  = 4;
  localparam int C3_WIDTH = 5;
  localparam int P3_HSYNC = 3;
  localparam int P3_VSYNC = 4;
  localparam int CNT_MISS = 6;
  localparam int CNT_POL  = 7;
  localparam int IRQ_SCL  = 0;
  localparam int IRQ_CONV = 1;
  localparam int IRQ_ID   = 2;
  localparam int IRQ_SAFE = 3;
  localparam int IRQ_VERT = 4;
  localparam int IRQ_PARA = 5;
  localparam int IRQ_NUM  = 6;
  localparam int PARA_W   = 13;

  // ========================================================================
  // carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mcs_bus_req_t;

  typedef struct packed {
    logic [11:0] hcount;
    logic        hsync_missing;
    logic        hsync_polarity;
    logic [11:0] vcount;
    logic        vsync_missing;
    logic        vsync_polarity;
  } mcs_sync_stat_t;

  typedef struct packed {
    logic clock_line_low;
    logic conversion_done;
    logic id_buffer_empty;
    logic safe_area;
    logic vsync_pulse;
    logic hsync_pulse;
  } mcs_event_t;

endpackage : mcs_pkg

// ===== src/mcs_hfreq_path.sv
// horizontal frequency passthrough with divider and polarity
`timescale 1ns/1ps
module mcs_hfreq_path
  import mcs_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic clk_en_in,
  input  wire logic enable_in,
  input  wire logic polarity_in,
  input  wire logic divide_in,
  input  wire logic hfreq_in,
  output logic      hfreq_out,
  output logic      hfreq_out_oe_n_out
);
  // ========================================================================
  // pin synchroniser
  logic sync_a;
  logic sync_b;
  logic sync_q;
  logic half;
  logic level;

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      sync_a <= hfreq_in;
      sync_b <= sync_a;
      sync_q <= sync_b;
    end

  // ========================================================================
  // half rate toggles on each rising input edge
  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      half <= 1'b0;
    else if (clk_en_in && sync_b && !sync_q)
      half <= ~half;

  assign level = divide_in ? half : sync_q;

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
    begin
      hfreq_out          <= 1'b0;
      hfreq_out_oe_n_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      hfreq_out          <= enable_in & (level ^ polarity_in);
      hfreq_out_oe_n_out <= ~enable_in;
    end

  chk_hfo_oe_follow: assert property (
    @(posedge clock_in) disable iff (rst_in)
    clk_en_in |=> hfreq_out_oe_n_out == !$past(enable_in))
    else $error("hfreq pin enable does not follow control");

  chk_hfo_polarity: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && enable_in && !divide_in)
      |=> hfreq_out == ($past(sync_q) ^ $past(polarity_in)))
    else $error("hfreq output polarity wrong");

  chk_hfo_divide: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && divide_in && sync_b && !sync_q)
      |=> half != $past(half))
    else $error("half rate divider did not toggle");
endmodule : mcs_hfreq_path

// ===== src/mcs_parabola_gen.sv
// parabola interrupt generator counting lines within a frame
`timescale 1ns/1ps
module mcs_parabola_gen
  import mcs_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              clk_en_in,
  input  wire logic [PARA_W-1:0] period_in,
  input  wire logic              line_in,
  input  wire logic              frame_in,
  output logic                   event_out
);
  // ========================================================================
  // line counter, restarted by each frame
  logic [PARA_W-1:0] count;
  logic [PARA_W-1:0] next_count;
  logic              hit;

  assign next_count = count + {{(PARA_W-1){1'b0}}, 1'b1};
  // period zero never matches, so it parks the generator
  assign hit = line_in && (period_in != '0) && (next_count == period_in);

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      count <= '0;
    else if (clk_en_in)
    begin
      if (frame_in || hit)
        count <= '0;
      else if (line_in)
        count <= next_count;
    end

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      event_out <= 1'b0;
    else if (clk_en_in)
      event_out <= hit && !frame_in;

  // a held pulse is checked only on the edge that launched it
  chk_para_period: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (event_out && $past(clk_en_in))
      |-> $past(next_count) == $past(period_in))
    else $error("parabola event off its period");
endmodule : mcs_parabola_gen

// ===== src/mcs_ctrl_regs.sv
// control and status register group of the monitor controller
`timescale 1ns/1ps
module mcs_ctrl_regs
  import mcs_pkg::*;
(
  input  wire logic           clock_in,
  input  wire logic           rst_in,
  input  wire logic           clk_en_in,
  input  wire mcs_bus_req_t   bus_in,
  output logic [7:0]          rdata_out,
  input  wire mcs_sync_stat_t sync_stat_in,
  input  wire mcs_event_t     event_in,
  input  wire logic           hdummy_select_lo_in,
  input  wire logic           hfreq_in,
  input  wire logic [7:0]     port1_latch_in,
  input  wire logic [3:0]     port2_latch_in,
  input  wire logic [1:0]     port3_latch_in,
  input  wire logic [10:0]    dac_pwm_in,
  input  wire logic           hclamp_in,
  input  wire logic           horizontal_sync_out_in,
  input  wire logic           vertical_sync_out_in,
  output logic                irq_out,
  output logic                xram_bank_select_out,
  output logic [1:0]          hdummy_select_out,
  output logic                hfreq_path_enable_out,
  output logic                hfreq_out,
  output logic                hfreq_out_oe_n_out,
  output logic [7:0]          port1_pin_out,
  output logic [3:0]          port2_pin_out,
  output logic [1:0]          port3_pin_out,
  output logic [3:0]          adc_input_enable_out
);
  // ========================================================================
  // bus strobes
  logic wr_go;
  logic rd_go;

  assign wr_go = clk_en_in & bus_in.wr;
  assign rd_go = clk_en_in & bus_in.rd;

  // ========================================================================
  // control_three
  logic [C3_WIDTH-1:0] control_three;

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      control_three <= RST_BYTE[C3_WIDTH-1:0];
    else if (wr_go && bus_in.addr == OFS_CONTROL_THREE)
      control_three <= bus_in.wdata[C3_WIDTH-1:0];

  // bank select and dummy select high bit come straight from flip-flops, dummy low bit from hdummy_select_lo_in
  assign xram_bank_select_out  = control_three[C3_BANK];
  assign hdummy_select_out     = {control_three[C3_HDUM],
                                  hdummy_select_lo_in};
  assign hfreq_path_enable_out = control_three[C3_HF_EN];

  mcs_hfreq_path u_hfreq (
    .clock_in           (clock_in),
    .rst_in             (rst_in),
    .clk_en_in          (clk_en_in),
    .enable_in          (control_three[C3_HF_EN]),
    .polarity_in        (control_three[C3_POL]),
    .divide_in          (control_three[C3_HALF]),
    .hfreq_in           (hfreq_in),
    .hfreq_out          (hfreq_out),
    .hfreq_out_oe_n_out (hfreq_out_oe_n_out)
  );

  // ========================================================================
  // port special function enables
  logic [7:0] port1_alt_enable;
  logic [7:0] port2_alt_enable;
  logic [1:0] port3_alt_enable;

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      port1_alt_enable <= RST_BYTE;
    else if (wr_go && bus_in.addr == OFS_PORT1_ALT)
      port1_alt_enable <= bus_in.wdata;

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      port2_alt_enable <= RST_BYTE;
    else if (wr_go && bus_in.addr == OFS_PORT2_ALT)
      port2_alt_enable <= bus_in.wdata;

  // only pins 3 and 4 have a special function
  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      port3_alt_enable <= RST_BYTE[1:0];
    else if (wr_go && bus_in.addr == OFS_PORT3_ALT)
      port3_alt_enable <= bus_in.wdata[P3_VSYNC:P3_HSYNC];

  assign adc_input_enable_out = port2_alt_enable[7:4];

  // ========================================================================
  // pin multiplexers, registered so pins never glitch on a decode
  logic [3:0] port2_source;

  assign port2_source = {hclamp_in, dac_pwm_in[10:8]};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      always_ff @(posedge clock_in or posedge rst_in)
        if (rst_in)
          port1_pin_out[gi] <= 1'b0;
        else if (clk_en_in)
          port1_pin_out[gi] <= port1_alt_enable[gi] ?
                               dac_pwm_in[gi] :
                               port1_latch_in[gi];
      if (gi < 4)
      begin : g_p2
        always_ff @(posedge clock_in or posedge rst_in)
          if (rst_in)
            port2_pin_out[gi] <= 1'b0;
          else if (clk_en_in)
            port2_pin_out[gi] <= port2_alt_enable[gi] ?
                                 port2_source[gi] :
                                 port2_latch_in[gi];
      end
    end
  endgenerate

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      port3_pin_out <= 2'b00;
    else if (clk_en_in)
    begin
      port3_pin_out[0] <= port3_alt_enable[0] ?
                          horizontal_sync_out_in :
                          port3_latch_in[0];
      port3_pin_out[1] <= port3_alt_enable[1] ?
                          vertical_sync_out_in :
                          port3_latch_in[1];
    end

  // ========================================================================
  // parabola period
  logic [7:0]        parabola_period_low;
  logic [4:0]        parabola_period_high;
  logic [PARA_W-1:0] parabola_period;
  logic              parabola_event;

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      parabola_period_low <= RST_BYTE;
    else if (wr_go && bus_in.addr == OFS_PARA_LOW)
      parabola_period_low <= bus_in.wdata;

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      parabola_period_high <= RST_PARA_HIGH;
    else if (wr_go && bus_in.addr == OFS_PARA_HIGH)
      parabola_period_high <= bus_in.wdata[4:0];

  assign parabola_period = {parabola_period_high, parabola_period_low};

  mcs_parabola_gen u_para (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .clk_en_in (clk_en_in),
    .period_in (parabola_period),
    .line_in   (event_in.hsync_pulse),
    .frame_in  (event_in.vsync_pulse),
    .event_out (parabola_event)
  );

  // ========================================================================
  // interrupt vector, mask and acknowledge
  logic [IRQ_NUM-1:0] irq_pending;
  logic [IRQ_NUM-1:0] irq_enable;
  logic [IRQ_NUM-1:0] irq_set;
  logic [IRQ_NUM-1:0] irq_clear;
  logic [IRQ_NUM-1:0] next_irq_pending;
  logic               vsync_missing_q;

  // missing flag edge so a dead input raises the vertical flag once only
  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      vsync_missing_q <= 1'b0;
    else if (clk_en_in)
      vsync_missing_q <= sync_stat_in.vsync_missing;

  always_comb
  begin
    irq_set           = '0;
    irq_set[IRQ_SCL]  = event_in.clock_line_low;
    irq_set[IRQ_CONV] = event_in.conversion_done;
    irq_set[IRQ_ID]   = event_in.id_buffer_empty;
    irq_set[IRQ_SAFE] = event_in.safe_area;
    irq_set[IRQ_VERT] = event_in.vsync_pulse |
                        (sync_stat_in.vsync_missing &
                         ~vsync_missing_q);
    irq_set[IRQ_PARA] = parabola_event;
  end

  // a zero bit in the ack byte selects nothing
  assign irq_clear = (wr_go && bus_in.addr == OFS_IRQ_ACK) ?
                     bus_in.wdata[IRQ_NUM-1:0] : '0;

  // set wins over a clear in the same cycle so no event is lost
  assign next_irq_pending = (irq_pending & ~irq_clear) | irq_set;

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      irq_pending <= RST_IRQ;
    else if (clk_en_in)
      irq_pending <= next_irq_pending;

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      irq_enable <= RST_IRQ;
    else if (wr_go && bus_in.addr == OFS_IRQ_ENABLE)
      irq_enable <= bus_in.wdata[IRQ_NUM-1:0];

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      irq_out <= 1'b0;
    else if (clk_en_in)
      irq_out <= |(next_irq_pending & irq_enable);

  // ========================================================================
  // read data, registered one cycle after the read strobe
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = 8'h00;
    unique case (bus_in.addr)
      OFS_HCOUNT_LOW:
        next_rdata = sync_stat_in.hcount[7:0];
      OFS_HCOUNT_HIGH:
        next_rdata = {sync_stat_in.hsync_polarity,
                      sync_stat_in.hsync_missing,
                      2'b00,
                      sync_stat_in.hcount[11:8]};
      OFS_VCOUNT_LOW:
        next_rdata = sync_stat_in.vcount[7:0];
      OFS_VCOUNT_HIGH:
        next_rdata = {sync_stat_in.vsync_polarity,
                      sync_stat_in.vsync_missing,
                      2'b00,
                      sync_stat_in.vcount[11:8]};
      OFS_IRQ_PENDING:
        next_rdata = {2'b00, irq_pending};
      OFS_IRQ_ENABLE:
        next_rdata = {2'b00, irq_enable};
      OFS_PARA_LOW:
        next_rdata = parabola_period_low;
      OFS_PARA_HIGH:
        next_rdata = {3'b000, parabola_period_high};
      // write-only and unmapped addresses read as zero
      default:
        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      rdata_out <= 8'h00;
    else if (rd_go)
      rdata_out <= next_rdata;

  // ========================================================================
  // checks
  chk_bank_write: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (wr_go && bus_in.addr == OFS_CONTROL_THREE)
      |=> xram_bank_select_out == $past(bus_in.wdata[C3_BANK]))
    else $error("bank select not taken from write");

  chk_dummy_hi: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (wr_go && bus_in.addr == OFS_CONTROL_THREE)
      |=> hdummy_select_out[1] == $past(bus_in.wdata[C3_HDUM]))
    else $error("dummy select high bit not taken");

  chk_port1_route: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && port1_alt_enable[0])
      |=> port1_pin_out[0] == $past(dac_pwm_in[0]))
    else $error("port 1 pin 0 not driven by its converter");

  chk_clamp_route: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && port2_alt_enable[3])
      |=> port2_pin_out[3] == $past(hclamp_in))
    else $error("clamp pulse not on port 2 pin 3");

  chk_adc_enable: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (wr_go && bus_in.addr == OFS_PORT2_ALT)
      |=> adc_input_enable_out == $past(bus_in.wdata[7:4]))
    else $error("converter input enables wrong");

  chk_vsync_route: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && port3_alt_enable[1])
      |=> port3_pin_out[1] == $past(vertical_sync_out_in))
    else $error("vertical sync not on port 3 pin 4");

  chk_hcount_read: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (rd_go && bus_in.addr == OFS_HCOUNT_HIGH)
      |=> rdata_out == {$past(sync_stat_in.hsync_polarity),
                        $past(sync_stat_in.hsync_missing), 2'b00,
                        $past(sync_stat_in.hcount[11:8])})
    else $error("horizontal count high byte wrong");

  chk_vert_once: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && sync_stat_in.vsync_missing && vsync_missing_q &&
     !event_in.vsync_pulse && !irq_pending[IRQ_VERT])
      |=> !irq_pending[IRQ_VERT])
    else $error("vertical flag raised again without sync");

  chk_ack_clears: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (irq_clear[IRQ_CONV] && !irq_set[IRQ_CONV])
      |=> !irq_pending[IRQ_CONV])
    else $error("acknowledge did not clear flag");

  chk_ack_zero_keeps: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (wr_go && bus_in.addr == OFS_IRQ_ACK && irq_pending[IRQ_CONV] &&
     !bus_in.wdata[IRQ_CONV]) |=> irq_pending[IRQ_CONV])
    else $error("zero acknowledge bit cleared a flag");

  chk_irq_request: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (clk_en_in && |(irq_pending & irq_enable & ~irq_clear)) ##1 clk_en_in
      |-> irq_out)
    else $error("interrupt request missing");
endmodule : mcs_ctrl_regs

// ===== testbench/mcs_ctrl_regs_bench.sv
// self-checking bench for the control and status registers
`timescale 1ns/1ps
module mcs_ctrl_regs_bench;
  import mcs_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clock_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1;
  logic hdummy_select_lo_in = 1'b1, hfreq_in = 1'b0;
  logic hclamp_in = 1'b1, horizontal_sync_out_in = 1'b1;
  logic vertical_sync_out_in = 1'b0;
  mcs_bus_req_t   bus_in = '0;
  mcs_sync_stat_t sync_stat_in = '0;
  mcs_event_t     event_in = '0;
  logic [7:0]     port1_latch_in = 8'h0f;
  logic [3:0]     port2_latch_in = 4'h0;
  logic [1:0]     port3_latch_in = 2'h2;
  logic [10:0]    dac_pwm_in = 11'h555;
  logic [7:0]     rdata_out, port1_pin_out;
  logic [3:0]     port2_pin_out, adc_input_enable_out;
  logic [1:0]     port3_pin_out, hdummy_select_out;
  logic irq_out, xram_bank_select_out, hfreq_path_enable_out;
  logic hfreq_out, hfreq_out_oe_n_out;
  int   fail_count = 0, comparisons = 0, cycles = 0;
  int   n;

  mcs_ctrl_regs dut (.clock_in, .rst_in, .clk_en_in, .bus_in,
    .rdata_out, .sync_stat_in, .event_in, .hdummy_select_lo_in,
    .hfreq_in, .port1_latch_in, .port2_latch_in, .port3_latch_in,
    .dac_pwm_in, .hclamp_in, .horizontal_sync_out_in,
    .vertical_sync_out_in, .irq_out, .xram_bank_select_out,
    .hdummy_select_out, .hfreq_path_enable_out, .hfreq_out,
    .hfreq_out_oe_n_out, .port1_pin_out, .port2_pin_out,
    .port3_pin_out, .adc_input_enable_out);

  // ==========================================================
  // clock and hang guard
  initial
  begin
    forever #25 clock_in = ~clock_in;
  end
  // whole run needs about 300 cycles
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fail_count++;
      conclude();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp)
      fail_count++;
  endtask : chk
  // idle cycle after each access keeps strobes single-assigned
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_in = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clock_in);
    bus_in.wr = 1'b0;
    @(negedge clock_in);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    bus_in = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clock_in);
    bus_in.rd = 1'b0;
    chk(rdata_out, exp);
    @(negedge clock_in);
  endtask : rc
  task automatic pulse(input logic [5:0] v);
    event_in = v;
    @(negedge clock_in);
    event_in = '0;
    @(negedge clock_in);
  endtask : pulse
  // counts output edges while the input toggles every 4 cycles
  task automatic hf_edges(output int cnt);
    logic last;
    cnt = 0;
    last = hfreq_out;
    for (int i = 0; i < 72; i++)
    begin
      if (i < 64 && i % 4 == 0)
        hfreq_in = ~hfreq_in;
      @(negedge clock_in);
      if (hfreq_out !== last)
        cnt++;
      last = hfreq_out;
    end
  endtask : hf_edges

  // ==========================================================
  // scenarios
  task automatic t_ctrl;
    chk(hfreq_out_oe_n_out, 8'h01);
    rc(OFS_CONTROL_THREE, 8'h00);
    rc(8'h7f, 8'h00);
    wr(OFS_CONTROL_THREE, 8'h1e);
    chk(xram_bank_select_out, 8'h01);
    chk(hdummy_select_out, 8'h03);
    chk(hfreq_path_enable_out, 8'h00);
    wr(OFS_CONTROL_THREE, 8'h01);
    hfreq_in = 1'b1;
    repeat (6) @(negedge clock_in);
    chk(xram_bank_select_out, 8'h00);
    chk(hdummy_select_out, 8'h01);
    chk({hfreq_path_enable_out, hfreq_out_oe_n_out}, 8'h02);
    chk(hfreq_out, 8'h01);
    wr(OFS_CONTROL_THREE, 8'h05);
    repeat (4) @(negedge clock_in);
    chk(hfreq_out, 8'h00);
    wr(OFS_CONTROL_THREE, 8'h09);
    hf_edges(n);
    chk(8'(n), 8'h08);
    wr(OFS_CONTROL_THREE, 8'h01);
    repeat (6) @(negedge clock_in);
    hf_edges(n);
    chk(8'(n), 8'h10);
    $display("control test done");
  endtask : t_ctrl

  task automatic t_ports;
    wr(OFS_PORT1_ALT, 8'h3c);
    wr(OFS_PORT2_ALT, 8'hab);
    wr(OFS_PORT3_ALT, 8'h10);
    chk(port1_pin_out, (8'h3c & dac_pwm_in[7:0]) | 8'h03);
    chk(port2_pin_out, {hclamp_in, 1'b0, dac_pwm_in[9:8]});
    chk(adc_input_enable_out, 8'h0a);
    chk(port3_pin_out, {vertical_sync_out_in, 1'b0});
    wr(OFS_PORT3_ALT, 8'h08);
    chk(port3_pin_out, 8'h03);
    $display("port test done");
  endtask : t_ports

  task automatic t_counts;
    sync_stat_in = '{12'habc, 1'b1, 1'b0, 12'h5d3, 1'b0, 1'b1};
    @(negedge clock_in);
    rc(OFS_HCOUNT_LOW, 8'hbc);
    rc(OFS_HCOUNT_HIGH, 8'h4a);
    rc(OFS_VCOUNT_LOW, 8'hd3);
    rc(OFS_VCOUNT_HIGH, 8'h85);
    $display("count test done");
  endtask : t_counts

  task automatic t_irq;
    rc(OFS_IRQ_ENABLE, 8'h00);
    rc(OFS_IRQ_PENDING, 8'h00);
    pulse(6'h10);
    rc(OFS_IRQ_PENDING, 8'h02);
    chk(irq_out, 8'h00);
    wr(OFS_IRQ_ENABLE, 8'h02);
    chk(irq_out, 8'h01);
    rc(OFS_IRQ_ENABLE, 8'h02);
    wr(OFS_IRQ_ACK, 8'h3d);
    rc(OFS_IRQ_PENDING, 8'h02);
    wr(OFS_IRQ_ACK, 8'h02);
    rc(OFS_IRQ_PENDING, 8'h00);
    chk(irq_out, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      pulse(6'h20 >> k);
      rc(OFS_IRQ_PENDING, 8'h01 << k);
      wr(OFS_IRQ_ACK, 8'h01 << k);
    end
    sync_stat_in.vsync_missing = 1'b1;
    repeat (3) @(negedge clock_in);
    rc(OFS_IRQ_PENDING, 8'h10);
    wr(OFS_IRQ_ACK, 8'h10);
    repeat (4) @(negedge clock_in);
    rc(OFS_IRQ_PENDING, 8'h00);
    wr(OFS_PARA_LOW, 8'h5a);
    wr(OFS_PARA_HIGH, 8'hff);
    rc(OFS_PARA_LOW, 8'h5a);
    rc(OFS_PARA_HIGH, 8'h1f);
    wr(OFS_PARA_LOW, 8'h02);
    wr(OFS_PARA_HIGH, 8'h00);
    pulse(6'h02);
    repeat (3) pulse(6'h01);
    rc(OFS_IRQ_PENDING, 8'h30);
    $display("interrupt test done");
  endtask : t_irq

  // frozen accesses must be ignored, then a mid-run reset
  task automatic t_hold;
    clk_en_in = 1'b0;
    wr(OFS_IRQ_ACK, 8'h30);
    wr(OFS_PORT1_ALT, 8'h00);
    clk_en_in = 1'b1;
    rc(OFS_IRQ_PENDING, 8'h30);
    chk(port1_pin_out, 8'h17);
    sync_stat_in.vsync_missing = 1'b0;
    rst_in = 1'b1;
    @(negedge clock_in);
    rst_in = 1'b0;
    @(negedge clock_in);
    chk(port1_pin_out, port1_latch_in);
    chk({irq_out, hfreq_out_oe_n_out}, 8'h01);
    rc(OFS_IRQ_ENABLE, 8'h00);
    rc(OFS_PARA_LOW, 8'h00);
    $display("hold and reset test done");
  endtask : t_hold

  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (8) @(negedge clock_in);
    rst_in = 1'b0;
    @(negedge clock_in);
    t_ctrl();
    t_ports();
    t_counts();
    t_irq();
    t_hold();
    conclude();
  end
endmodule : mcs_ctrl_regs_bench
